// >>> rtl/aqc_pkg.sv
// aqc_pkg: character codes, field limits and reply sizes of the query interpreter
// assumes: one byte per character, received and sent as ascii over a byte port
package aqc_pkg;
  localparam logic [7:0] CH_DOLLAR   = 8'h24;
  localparam logic [7:0] CH_HASH     = 8'h23;
  localparam logic [7:0] CH_OK       = 8'h21;
  localparam logic [7:0] CH_BAD      = 8'h3F;
  localparam logic [7:0] CH_CR       = 8'h0D;
  localparam logic [7:0] CH_ZERO     = 8'h30;
  localparam logic [7:0] CH_ONE      = 8'h31;
  localparam logic [7:0] CH_DOT      = 8'h2E;
  localparam logic [7:0] CH_C        = 8'h43;
  localparam logic [7:0] CH_F        = 8'h46;
  localparam logic [7:0] CH_L        = 8'h4C;
  localparam logic [7:0] CH_M        = 8'h4D;
  localparam int         RX_MAX      = 8;
  localparam int         TX_MAX      = 16;
  localparam int         CNT_CHANNELS = 1;
  localparam int         CNT_W        = 16;
  localparam int         DO_W         = 8;
  localparam int         DI_W         = 8;
  localparam int         NAME_LEN     = 5;
  // firmware text digits, version 01.00
  localparam logic [7:0] FW_MAJ_HI  = 8'h30;
  localparam logic [7:0] FW_MAJ_LO  = 8'h31;
  localparam logic [7:0] FW_MIN_HI  = 8'h30;
  localparam logic [7:0] FW_MIN_LO  = 8'h30;
  // module name text, arbitrary value
  localparam logic [39:0] NAME_TEXT = 40'h4D4F443031;
  typedef enum logic [1:0] {AQC_IDLE, AQC_RECV, AQC_SEND} aqc_state_t;
endpackage : aqc_pkg

// >>> rtl/aqc_txbuf.sv
// aqc_txbuf: small reply character store with registered read data
// assumes: writer and reader on the same clock
module aqc_txbuf (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [3:0] rd_addr,
  output logic      [7:0] rd_data
);
  logic [7:0] mem_q [aqc_pkg::TX_MAX];
  logic [7:0] rd_q;

  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_q <= 8'h00;
    end
    else
    begin
      rd_q <= mem_q[rd_addr];
    end
  end

  assign rd_data = rd_q;
endmodule : aqc_txbuf

// >>> rtl/aqc_top.sv
// aqc_top: ascii query interpreter for an addressed digital io module
// assumes: rx bytes arrive one per rx_valid pulse; tx drained with tx_ready
// Operation
// - latch clear resets low and high latches
// - counter clear frame: delimiter, address, C, digit
// - accepted counter clear zeroes selected counter
// - no reply on bad syntax, checksum, address
// - replies carry marker, own address except latch reads, checksum, terminator
// - missing counter channel gives invalid reply
// - firmware query replies marker, address, version
// - version text is two digits, dot, two
// - latch read selector 0 low, 1 high
// - latch reply marker, four digits, two zeros
// - low latch reads zero after clear
// - latch clear replies marker and address
// - name query replies marker, address, name
// - output status first, input status last
module aqc_top (
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic [7:0]                    module_address,
  input  wire logic                          checksum_enable,
  input  wire logic [7:0]                    rx_data,
  input  wire logic                          rx_valid,
  input  wire logic                          rx_error,
  input  wire logic [aqc_pkg::DO_W-1:0]      do_status,
  input  wire logic [aqc_pkg::DI_W-1:0]      di_status,
  input  wire logic [aqc_pkg::CNT_CHANNELS-1:0] di_pulse,
  output logic      [7:0]                    tx_data,
  output logic                               tx_valid,
  input  wire logic                          tx_ready,
  output logic      [aqc_pkg::CNT_W-1:0]     counter_value
);
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_char

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) hex_val = {1'b0, c[3:0]};
    else if (c >= 8'h41 && c <= 8'h46) hex_val = {1'b0, c[3:0] + 4'h9};
    else hex_val = 5'h10;
  endfunction : hex_val

  ////////////////////////////////////////////////////////////////////////////
  // state
  aqc_pkg::aqc_state_t state_q, state_d;
  logic [7:0] rx_q [aqc_pkg::RX_MAX];
  logic [7:0] rx_d [aqc_pkg::RX_MAX];
  logic [3:0] rx_len_q, rx_len_d;
  logic       rx_bad_q, rx_bad_d;
  logic [3:0] tx_len_q, tx_len_d, tx_idx_q, tx_idx_d;
  logic       tx_valid_q, tx_valid_d;
  logic [7:0] tx_data_q, tx_data_d;
  logic       fetch_q, fetch_d;
  localparam int DO_W_T = aqc_pkg::DO_W + aqc_pkg::DI_W;
  logic [DO_W_T-1:0] low_q, low_d, high_q, high_d, prev_q;
  logic       primed_q;
  logic [4:0] addr_hi, addr_lo, chan;
  logic [3:0] fill_q, fill_d;
  logic       filling_q, filling_d;
  logic [7:0] hold_q [aqc_pkg::TX_MAX];
  logic [7:0] hold_d [aqc_pkg::TX_MAX];
  logic       bwr_en;
  logic [aqc_pkg::CNT_W-1:0] cnt_q [aqc_pkg::CNT_CHANNELS];
  logic [aqc_pkg::CNT_W-1:0] cnt_d [aqc_pkg::CNT_CHANNELS];
  logic       wr_en;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] sum;
  logic [3:0] body;
  logic       ok;
  logic       clr_cnt, clr_latch;
  logic [DO_W_T-1:0] now;

  assign now     = {do_status, di_status};
  assign addr_hi = hex_val(rx_q[1]);
  assign addr_lo = hex_val(rx_q[2]);
  assign chan    = hex_val(rx_q[4]);
  assign bwr_en  = filling_q;
  assign wr_addr = fill_q;
  assign wr_data = hold_q[fill_q];

  aqc_txbuf u_buf (
    .clock   (clock),
    .rst_n   (rst_n),
    .wr_en   (bwr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (tx_idx_d),
    .rd_data (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // receive, decode and build the reply
  always_comb
  begin
    state_d   = state_q;
    rx_d      = rx_q;
    rx_len_d  = rx_len_q;
    rx_bad_d  = rx_bad_q;
    tx_len_d  = tx_len_q;
    tx_idx_d  = tx_idx_q;
    tx_valid_d = tx_valid_q;
    tx_data_d = tx_data_q;
    fetch_d   = 1'b0;
    wr_en     = 1'b0;
    clr_cnt   = 1'b0;
    clr_latch = 1'b0;
    sum       = 8'h00;
    body      = rx_len_q;
    ok        = 1'b0;
    case (state_q)
      aqc_pkg::AQC_IDLE:
      begin
        if (rx_valid && (rx_data == aqc_pkg::CH_DOLLAR || rx_data == aqc_pkg::CH_HASH))
        begin
          rx_d[0]  = rx_data;
          rx_len_d = 4'h1;
          rx_bad_d = rx_error;
          state_d  = aqc_pkg::AQC_RECV;
        end
      end
      aqc_pkg::AQC_RECV:
      begin
        if (rx_valid && rx_data != aqc_pkg::CH_CR)
        begin
          if (rx_len_q < 4'(aqc_pkg::RX_MAX))
          begin
            rx_d[rx_len_q[2:0]] = rx_data;
            rx_len_d = rx_len_q + 4'h1;
          end
          else
          begin
            rx_bad_d = 1'b1;
          end
          if (rx_error)
          begin
            rx_bad_d = 1'b1;
          end
        end
        else if (rx_valid)
        begin
          // checksum strip and verify
          if (checksum_enable)
          begin
            body = rx_len_q - 4'h2;
          end
          for (int i = 0; i < aqc_pkg::RX_MAX; i++)
          begin
            if (4'(i) < body)
            begin
              sum = sum + rx_q[i];
            end
          end
          ok = !rx_bad_q && !rx_error && body >= 4'h4;
          if (checksum_enable && (rx_len_q < 4'h6 ||
              {hex_char(sum[7:4]), hex_char(sum[3:0])} !=
              {rx_q[body[2:0]], rx_q[3'(body + 4'h1)]}))
          begin
            ok = 1'b0;
          end
          if (addr_hi > 5'hF || addr_lo > 5'hF ||
              {addr_hi[3:0], addr_lo[3:0]} != module_address)
          begin
            ok = 1'b0;
          end
          tx_len_d = 4'h0;
          state_d  = aqc_pkg::AQC_IDLE;
          if (ok)
          begin
            // default ok answer with address
            tx_len_d = 4'h3;
            wr_en = 1'b1;
            if (rx_q[0] == aqc_pkg::CH_DOLLAR && rx_q[3] == aqc_pkg::CH_C && body == 4'h4)
            begin
              clr_latch = 1'b1;
              tx_len_d  = 4'h3;
            end
            else if (rx_q[0] == aqc_pkg::CH_DOLLAR && rx_q[3] == aqc_pkg::CH_C && body == 4'h5)
            begin
              if (hex_val(rx_q[4]) < 5'(aqc_pkg::CNT_CHANNELS) && rx_q[4] <= 8'h39)
              begin
                clr_cnt = 1'b1;
              end
              else
              begin
                tx_len_d = 4'hF;
              end
            end
            else if (rx_q[0] == aqc_pkg::CH_DOLLAR && rx_q[3] == aqc_pkg::CH_F && body == 4'h4)
            begin
              tx_len_d = 4'h8;
            end
            else if (rx_q[0] == aqc_pkg::CH_DOLLAR && rx_q[3] == aqc_pkg::CH_L && body == 4'h5 &&
                     (rx_q[4] == aqc_pkg::CH_ZERO || rx_q[4] == aqc_pkg::CH_ONE))
            begin
              tx_len_d = 4'h7;
            end
            else if (rx_q[0] == aqc_pkg::CH_DOLLAR && rx_q[3] == aqc_pkg::CH_M && body == 4'h4)
            begin
              tx_len_d = 4'(3 + aqc_pkg::NAME_LEN);
            end
            else if (rx_q[0] == aqc_pkg::CH_HASH && body == 4'h4 &&
                     hex_val(rx_q[3]) >= 5'(aqc_pkg::CNT_CHANNELS))
            begin
              tx_len_d = 4'hF;
            end
            else
            begin
              ok = 1'b0;
              wr_en = 1'b0;
              tx_len_d = 4'h0;
            end
            if (ok)
            begin
              tx_idx_d = 4'h0;
              state_d  = aqc_pkg::AQC_SEND;
            end
          end
        end
      end
      aqc_pkg::AQC_SEND:
      begin
        // first fetch only once the whole image sits in the store
        if (filling_q && fill_q == 4'hF)
        begin
          fetch_d = 1'b1;
        end
        if (tx_valid_q && tx_ready)
        begin
          tx_valid_d = 1'b0;
          tx_idx_d   = tx_idx_q + 4'h1;
          fetch_d    = 1'b1;
        end
        if (fetch_q)
        begin
          if (tx_idx_q < tx_len_q)
          begin
            tx_data_d  = rd_data;
            tx_valid_d = 1'b1;
          end
          else
          begin
            state_d = aqc_pkg::AQC_IDLE;
          end
        end
      end
      default:
      begin
        state_d = aqc_pkg::AQC_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply image: built from decoded length, then filled per character
  logic [7:0] img [aqc_pkg::TX_MAX];
  logic [7:0] csum;
  logic [3:0] n, send_len;
  logic [DO_W_T-1:0] latch_sel;

  always_comb
  begin
    n = (tx_len_d == 4'hF) ? 4'h3 : tx_len_d;
    send_len = wr_en ? 4'(n + (checksum_enable ? 4'h3 : 4'h1)) : tx_len_q;
    latch_sel = (rx_q[4] == aqc_pkg::CH_ONE) ? high_q : low_q;
    for (int i = 0; i < aqc_pkg::TX_MAX; i++)
    begin
      img[i] = aqc_pkg::CH_CR;
    end
    img[0] = (tx_len_d == 4'hF) ? aqc_pkg::CH_BAD : aqc_pkg::CH_OK;
    img[1] = hex_char(module_address[7:4]);
    img[2] = hex_char(module_address[3:0]);
    if (tx_len_d == 4'h8 && rx_q[3] == aqc_pkg::CH_F)
    begin
      img[3] = aqc_pkg::FW_MAJ_HI;
      img[4] = aqc_pkg::FW_MAJ_LO;
      img[5] = aqc_pkg::CH_DOT;
      img[6] = aqc_pkg::FW_MIN_HI;
      img[7] = aqc_pkg::FW_MIN_LO;
    end
    else if (tx_len_d == 4'h7)
    begin
      img[1] = hex_char(latch_sel[15:12]);
      img[2] = hex_char(latch_sel[11:8]);
      img[3] = hex_char(latch_sel[7:4]);
      img[4] = hex_char(latch_sel[3:0]);
      img[5] = aqc_pkg::CH_ZERO;
      img[6] = aqc_pkg::CH_ZERO;
    end
    else if (tx_len_d == 4'h8)
    begin
      for (int k = 0; k < aqc_pkg::NAME_LEN; k++)
      begin
        img[3 + k] = aqc_pkg::NAME_TEXT[8 * (aqc_pkg::NAME_LEN - 1 - k) +: 8];
      end
    end
    csum = 8'h00;
    for (int i = 0; i < aqc_pkg::TX_MAX; i++)
    begin
      if (4'(i) < n)
      begin
        csum = csum + img[i];
      end
    end
    if (checksum_enable)
    begin
      img[n] = hex_char(csum[7:4]);
      img[4'(n + 4'h1)] = hex_char(csum[3:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latches and counters
  always_comb
  begin
    low_d  = low_q | (prev_q & ~now);
    high_d = high_q | (~prev_q & now);
    if (clr_latch)
    begin
      low_d  = prev_q & ~now;
      high_d = ~prev_q & now;
    end
    if (!primed_q)
    begin
      low_d  = low_q;
      high_d = high_q;
    end
    for (int c = 0; c < aqc_pkg::CNT_CHANNELS; c++)
    begin
      cnt_d[c] = cnt_q[c] + (di_pulse[c] ? 16'h0001 : 16'h0000);
      if (clr_cnt && chan[3:0] == 4'(c))
      begin
        cnt_d[c] = '0;
      end
    end
  end

  // reply image written as a whole into the store, one slot per clock
  always_comb
  begin
    hold_d    = hold_q;
    fill_d    = fill_q;
    filling_d = filling_q;
    if (wr_en)
    begin
      hold_d    = img;
      fill_d    = 4'h0;
      filling_d = 1'b1;
    end
    else if (filling_q)
    begin
      fill_d    = fill_q + 4'h1;
      filling_d = (fill_q != 4'hF);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q    <= aqc_pkg::AQC_IDLE;
      rx_len_q   <= 4'h0;
      rx_bad_q   <= 1'b0;
      tx_len_q   <= 4'h0;
      tx_idx_q   <= 4'h0;
      tx_valid_q <= 1'b0;
      tx_data_q  <= 8'h00;
      fetch_q    <= 1'b0;
      low_q      <= '0;
      high_q     <= '0;
      prev_q     <= '0;
      primed_q   <= 1'b0;
      fill_q     <= 4'h0;
      filling_q  <= 1'b0;
      for (int i = 0; i < aqc_pkg::RX_MAX; i++)
      begin
        rx_q[i] <= 8'h00;
      end
      for (int i = 0; i < aqc_pkg::TX_MAX; i++)
      begin
        hold_q[i] <= 8'h00;
      end
      for (int c = 0; c < aqc_pkg::CNT_CHANNELS; c++)
      begin
        cnt_q[c] <= '0;
      end
    end
    else
    begin
      state_q    <= state_d;
      rx_q       <= rx_d;
      rx_len_q   <= rx_len_d;
      rx_bad_q   <= rx_bad_d;
      tx_len_q   <= send_len;
      tx_idx_q   <= tx_idx_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q  <= tx_data_d;
      fetch_q    <= fetch_d;
      low_q      <= low_d;
      high_q     <= high_d;
      prev_q     <= now;
      primed_q   <= 1'b1;
      fill_q     <= fill_d;
      filling_q  <= filling_d;
      hold_q     <= hold_d;
      cnt_q      <= cnt_d;
    end
  end

  assign tx_data       = tx_data_q;
  assign tx_valid      = tx_valid_q;
  assign counter_value = cnt_q[0];
endmodule : aqc_top

// >>> sim/aqc_host.sv
// aqc_host: host side of the ascii link, sends frames and drains replies
// assumes: one clock shared with the interpreter, bytes change 1 ns after the edge
module aqc_host (
  input  wire logic       clock,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            rx_error,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  int stall;
  initial
  begin
    rx_data  = 8'hA5;
    rx_valid = 1'b0;
    rx_error = 1'b0;
    tx_ready = 1'b0;
    stall    = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hexc
  // one byte, line shows the inverse once released
  task automatic put(input logic [7:0] c, input bit e);
    @(posedge clock);
    #1;
    rx_data  = c;
    rx_valid = 1'b1;
    rx_error = e;
    @(posedge clock);
    #1;
    rx_valid = 1'b0;
    rx_error = 1'b0;
    rx_data  = ~c;
  endtask : put
  task automatic send(input string s, input bit ck, input logic [7:0] adj, input int err_at);
    logic [7:0] sum;
    sum = adj;
    for (int i = 0; i < s.len(); i++)
    begin
      put(s[i], i == err_at);
      sum += s[i];
    end
    if (ck)
    begin
      put(hexc(sum[7:4]), 1'b0);
      put(hexc(sum[3:0]), 1'b0);
    end
    put(8'h0D, 1'b0);
  endtask : send
  // collect one reply up to the terminator, empty on silence
  task automatic take(output string r);
    logic [7:0] b;
    int         w;
    r = "";
    w = 0;
    b = 8'h00;
    for (int n = 0; n < 400; n++)
    begin
      @(posedge clock);
      #1;
      if (tx_ready)
      begin
        tx_ready = 1'b0;
        r = {r, string'(b)};
        n = 0;
        if (b == 8'h0D)
          return;
      end
      else if (tx_valid === 1'b1)
      begin
        if (w < stall)
          w++;
        else
        begin
          b = tx_data;
          tx_ready = 1'b1;
          w = 0;
        end
      end
    end
  endtask : take
endmodule : aqc_host

// >>> sim/aqc_top_asserts.sv
// aqc_top_asserts: port checks of the query interpreter
// assumes: bound to aqc_top, single clock, reset rst_n
module aqc_top_asserts (
  input wire logic                        clock,
  input wire logic                        rst_n,
  input wire logic [7:0]                  module_address,
  input wire logic                        checksum_enable,
  input wire logic [7:0]                  rx_data,
  input wire logic                        rx_valid,
  input wire logic [7:0]                  tx_data,
  input wire logic                        tx_valid,
  input wire logic                        tx_ready,
  input wire logic [aqc_pkg::CNT_W-1:0]   counter_value
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] len_q, len_d;
  logic       bad_q, bad_d, armed_q, armed_d, hs;
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hexc
  ////////////////////////////////////////////////////////////////////////////
  // reply position, marker kind, frame seen
  always_comb
  begin
    hs      = tx_valid && tx_ready;
    len_d   = hs ? ((tx_data == aqc_pkg::CH_CR) ? 5'h0 : len_q + 5'h1) : len_q;
    bad_d   = (hs && len_q == 5'h0) ? (tx_data == aqc_pkg::CH_BAD) : bad_q;
    armed_d = (rx_valid && rx_data == aqc_pkg::CH_CR) ? 1'b1 :
              ((hs && tx_data == aqc_pkg::CH_CR) ? 1'b0 : armed_q);
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      len_q   <= 5'h0;
      bad_q   <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      len_q   <= len_d;
      bad_q   <= bad_d;
      armed_q <= armed_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_hold;
    tx_valid && !tx_ready;
  endsequence
  sequence s_start;
    tx_valid && len_q == 5'h0;
  endsequence
  a_tx_holds: assert property (s_hold |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed before ready");
  a_reply_marker: assert property (s_start |-> tx_data inside {8'h21, 8'h3F})
    else $error("reply starts without marker");
  a_reply_after_cr: assert property ($rose(tx_valid) && len_q == 5'h0 |-> armed_q)
    else $error("reply without a received frame");
  a_count_step: assert property ($changed(counter_value) |->
    counter_value == $past(counter_value) + 16'h1 || (counter_value == 16'h0 && armed_q))
    else $error("counter moved other than count or clear");
  a_reply_bound: assert property (tx_valid |-> len_q < 5'd12)
    else $error("reply longer than any answer");
  a_second_hex: assert property (tx_valid && len_q == 5'h1 |->
    tx_data inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("second reply char not hex");
  a_bad_addr_hi: assert property (tx_valid && bad_q && len_q == 5'h1 |->
    tx_data == hexc(module_address[7:4]))
    else $error("invalid reply address high wrong");
  a_bad_addr_lo: assert property (tx_valid && bad_q && len_q == 5'h2 |->
    tx_data == hexc(module_address[3:0]))
    else $error("invalid reply address low wrong");
  a_bad_short: assert property (tx_valid && bad_q && len_q == 5'h3 |->
    tx_data == aqc_pkg::CH_CR || checksum_enable)
    else $error("invalid reply carries data");
endmodule : aqc_top_asserts
bind aqc_top aqc_top_asserts u_chk (.clock(clock), .rst_n(rst_n),
  .module_address(module_address), .checksum_enable(checksum_enable), .rx_data(rx_data),
  .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .counter_value(counter_value));

// >>> sim/aqc_top_test.sv
// aqc_top_test: self-checking bench of the query interpreter
// assumes: aqc_host drives the serial byte side, bench drives io levels
module aqc_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic                        clock, rst_n, checksum_enable, rx_valid, rx_error;
  logic                        tx_valid, tx_ready;
  logic [7:0]                  module_address, rx_data, tx_data, a;
  logic [aqc_pkg::DO_W-1:0]    do_status, lo_do, hi_do;
  logic [aqc_pkg::DI_W-1:0]    di_status, lo_di, hi_di;
  logic [aqc_pkg::CNT_CHANNELS-1:0] di_pulse;
  logic [aqc_pkg::CNT_W-1:0]   counter_value;
  int                          n_fail, n_compared, seed, k;
  string                       r, aa, nm;
  aqc_top dut (.clock(clock), .rst_n(rst_n), .module_address(module_address),
    .checksum_enable(checksum_enable), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_error(rx_error), .do_status(do_status), .di_status(di_status), .di_pulse(di_pulse),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .counter_value(counter_value));
  aqc_host host (.clock(clock), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_error(rx_error), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic string hx2(input logic [7:0] v);
    return {string'(host.hexc(v[7:4])), string'(host.hexc(v[3:0]))};
  endfunction : hx2
  function automatic string reply(input string b);
    logic [7:0] s;
    s = 8'h00;
    foreach (b[j]) s += b[j];
    return checksum_enable ? {b, hx2(s), "\r"} : {b, "\r"};
  endfunction : reply
  task automatic check(input string what, input string seen, input string exp);
    n_compared++;
    if (seen != exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %s seen %s", what, exp, seen);
    end
  endtask : check
  task automatic cmd(input string s, input logic [7:0] adj, input int e, input string exp);
    host.send(s, checksum_enable, adj, e);
    host.take(r);
    check(s, r, exp);
  endtask : cmd
  // new io levels, tracked edges into expected latches
  task automatic set_io(input logic [7:0] d, input logic [7:0] i);
    @(posedge clock);
    #1;
    lo_do |= do_status & ~d;
    hi_do |= ~do_status & d;
    lo_di |= di_status & ~i;
    hi_di |= ~di_status & i;
    do_status = d;
    di_status = i;
  endtask : set_io
  task automatic tally_and_finish;
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (100000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h975424f2;
    {n_fail, n_compared} = '0;
    {rst_n, checksum_enable, di_pulse, do_status, di_status} = '0;
    {lo_do, lo_di, hi_do, hi_di} = '0;
    a = 8'($random(seed));
    module_address = a;
    aa = hx2(a);
    nm = "";
    for (k = 0; k < aqc_pkg::NAME_LEN; k++)
      nm = {nm, string'(aqc_pkg::NAME_TEXT[8*(aqc_pkg::NAME_LEN-k)-1 -: 8])};
    repeat (8) @(posedge clock);
    #1 rst_n = 1'b1;
    for (int ck = 0; ck < 2; ck++)
    begin
      checksum_enable = ck[0];
      host.stall = 3 * ck;
      cmd({"$", aa, "F"}, 8'h00, -1, reply({"!", aa, "01.00"}));
      cmd({"$", aa, "M"}, 8'h00, -1, reply({"!", aa, nm}));
      cmd({"$", hx2(a + 8'h01), "F"}, 8'h00, -1, "");
      cmd({"$", aa, "F"}, 8'h00, 2, "");
      cmd({"$", aa, "X"}, 8'h00, -1, "");
      if (ck == 1)
        cmd({"$", aa, "F"}, 8'h01, -1, "");
      cmd({"#", aa, "9"}, 8'h00, -1, reply({"?", aa}));
      k = 1 + ($random(seed) & 7);
      repeat (k)
      begin
        @(posedge clock);
        #1 di_pulse = 1'b1;
        @(posedge clock);
        #1 di_pulse = 1'b0;
      end
      check("count", $sformatf("%h", counter_value), $sformatf("%h", 16'(k)));
      cmd({"$", aa, "C1"}, 8'h00, -1, reply({"?", aa}));
      cmd({"$", aa, "C0"}, 8'h00, -1, reply({"!", aa}));
      check("cleared", $sformatf("%h", counter_value), "0000");
      repeat (6) set_io(8'($random(seed)), 8'($random(seed)));
      cmd({"$", aa, "L0"}, 8'h00, -1, reply({"!", hx2(lo_do), hx2(lo_di), "00"}));
      cmd({"$", aa, "L1"}, 8'h00, -1, reply({"!", hx2(hi_do), hx2(hi_di), "00"}));
      cmd({"$", aa, "C"}, 8'h00, -1, reply({"!", aa}));
      {lo_do, lo_di, hi_do, hi_di} = '0;
      cmd({"$", aa, "L0"}, 8'h00, -1, reply("!000000"));
      cmd({"$", aa, "L1"}, 8'h00, -1, reply("!000000"));
    end
    @(posedge clock);
    #1 di_pulse = 1'b1;
    @(posedge clock);
    #1 di_pulse = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1 rst_n = 1'b1;
    check("reset count", $sformatf("%h", counter_value), "0000");
    cmd({"$", aa, "L1"}, 8'h00, -1, reply("!000000"));
    cmd({"$", aa, "F"}, 8'h00, -1, reply({"!", aa, "01.00"}));
    tally_and_finish();
  end
endmodule : aqc_top_test
